// ==== design/sense_counter_comp_logic.sv ====
// Local design decision: the AXI4-Lite register port.
`default_nettype none
module sense_counter_comp_logic
   import sense_pkg::*;
#(
   parameter int COUNT_WIDTH = 8,
   parameter int PRESCALE = PRESCALE_DIV
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic comp0_raw,
   input wire logic comp1_raw,
   input wire logic comp0_latch,
   input wire logic pseudo_random_seq,
   input wire logic timer_one_config,
   output logic sense_pin_out,
   output logic switch_clock,
   output logic [1:0] timer_one_clock_source,
   output logic comp0_channel_out,
   output logic comp1_channel_out
);
   logic [7:0] func_sel;
   logic [7:0] cnt_ctrl;
   logic [3:0] chan_cfg;
   logic [2:0] cmp_sync;
   logic [1:0] lut_out;
   logic aw_held;
   logic w_held;
   logic [7:0] waddr;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   logic do_write;
   logic [31:0] rd_word;
   logic rd_hit;
   logic [$clog2(PRESCALE+1)-1:0] presc_cnt;
   logic presc_tick;
   logic presc_level;
   logic [2:0] div_cnt;
   logic [2:0] div_mask;
   logic count_tick;
   logic chan0_data;
   logic in_prev;
   logic in_rise;
   logic in_fall;
   logic [COUNT_WIDTH-1:0] low_count;
   logic [COUNT_WIDTH-1:0] high_count;
   logic counter_interrupt;
   logic wrap_event;
   logic enable;
   logic sigma_mode;
   count_mode_type mode;
   count_state_type state;
   count_state_type next_state;

   assign enable = cnt_ctrl[CTRL_EN];
   assign sigma_mode = cnt_ctrl[CTRL_SIGMA];
   assign mode = count_mode_type'(cnt_ctrl[CTRL_MODE_LSB +: 2]);

   // Comparators are asynchronous to clk; nothing reads them before two flops
   sync_two_ff #(.WIDTH(3)) u_sync (
      .clk(clk),
      .reset(reset),
      .async_in({comp0_latch, comp1_raw, comp0_raw}),
      .sync_out(cmp_sync)
   );

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_fn
         comp_function_unit u_fn (
            .function_code(func_sel[(g == 0 ? FN0_LSB : FN1_LSB) +: 4]),
            .operand_a(cmp_sync[g]),
            .operand_b(cmp_sync[1-g]),
            .result(lut_out[g])
         );
      end
   endgenerate

   assign chan0_data = chan_cfg[CFG_DATA_SEL] ? cmp_sync[2] : lut_out[0];

   // Bus slave: address and data are taken in either order, response follows both
   assign do_write = aw_held && w_held && !bvalid;

   always_ff @(posedge clk) begin
      if (reset) begin
         awready <= 1'b0;
         wready <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         waddr <= '0;
         wdata_q <= '0;
         wstrb0_q <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            awready <= 1'b0;
            waddr <= awaddr;
         end else if (!aw_held && !bvalid) begin
            awready <= 1'b1;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb0_q <= wstrb[0];
         end else if (!w_held && !bvalid) begin
            wready <= 1'b1;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (waddr == ADDR_FUNC_SEL || waddr == ADDR_CHAN_CFG ||
                      waddr == ADDR_CNT_CTRL || waddr == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Software must leave bits 7:1 alone while enabled; they are not locked here
   always_ff @(posedge clk) begin
      if (reset) begin
         func_sel <= RESET_FUNC_SEL;
         cnt_ctrl <= RESET_CNT_CTRL;
         chan_cfg <= RESET_CHAN_CFG;
      end else if (do_write && wstrb0_q) begin
         if (waddr == ADDR_FUNC_SEL) func_sel <= wdata_q[7:0];
         if (waddr == ADDR_CNT_CTRL) cnt_ctrl <= wdata_q[7:0];
         if (waddr == ADDR_CHAN_CFG) chan_cfg <= wdata_q[3:0];
      end
   end

   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      case (araddr)
         ADDR_FUNC_SEL: rd_word[7:0] = func_sel;
         ADDR_CNT_CTRL: rd_word[7:0] = cnt_ctrl;
         ADDR_CHAN_CFG: rd_word[3:0] = chan_cfg;
         ADDR_STATUS: begin
            rd_word[STAT_LOW_LSB +: COUNT_WIDTH] = low_count;
            rd_word[STAT_HIGH_LSB +: COUNT_WIDTH] = high_count;
            rd_word[STAT_ACTIVE] = (state == ST_COUNT);
            rd_word[STAT_CH0] = chan0_data;
            rd_word[STAT_CH1] = lut_out[1];
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // Free running from reset so its phase never jumps when the mode is set
   always_ff @(posedge clk) begin
      if (reset) begin
         presc_cnt <= '0;
         presc_level <= 1'b0;
      end else if (presc_tick) begin
         presc_cnt <= '0;
         presc_level <= ~presc_level;
      end else begin
         presc_cnt <= presc_cnt + 1'b1;
      end
   end
   assign presc_tick = (presc_cnt == ($clog2(PRESCALE+1))'(PRESCALE - 1));

   always_comb begin
      case (chan_cfg[CFG_RATIO_LSB +: 2])
         2'h0: div_mask = 3'h0;
         2'h1: div_mask = 3'h1;
         2'h2: div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         div_cnt <= '0;
      end else if (!cnt_ctrl[CTRL_SRCSEL] || presc_tick) begin
         div_cnt <= div_cnt + 1'b1;
      end
   end
   assign count_tick = (!cnt_ctrl[CTRL_SRCSEL] || presc_tick) &&
                       ((div_cnt & div_mask) == div_mask);

   assign in_rise = chan0_data && !in_prev;
   assign in_fall = !chan0_data && in_prev;

   always_ff @(posedge clk) begin
      if (reset) begin
         in_prev <= 1'b0;
      end else begin
         in_prev <= chan0_data;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (mode == MODE_EVENT || mode == MODE_CONTINUOUS) next_state = ST_COUNT;
            else next_state = ST_ARMED;
         end
         ST_ARMED: if (in_rise) next_state = ST_COUNT;
         ST_COUNT: begin
            if (mode == MODE_EVENT && counter_interrupt) next_state = ST_DONE;
            if (mode == MODE_PULSE && in_fall) next_state = ST_DONE;
            if (mode == MODE_PERIOD && in_rise) next_state = ST_DONE;
         end
         ST_DONE: next_state = ST_DONE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset || !enable) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign wrap_event = count_tick && sigma_mode && (state == ST_COUNT) && (&low_count) &&
                       (!chan_cfg[CFG_CHAIN] || (&high_count));

   always_ff @(posedge clk) begin
      if (reset || !enable) begin
         low_count <= '0;
         high_count <= '0;
         counter_interrupt <= 1'b0;
      end else begin
         counter_interrupt <= wrap_event;
         if (count_tick && sigma_mode && state == ST_COUNT) begin
            low_count <= low_count + 1'b1;
            // Chained: high steps on the low wrap, one synchronous 16-bit count
            if (!chan_cfg[CFG_CHAIN] || (&low_count)) high_count <= high_count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sense_pin_out <= 1'b0;
         switch_clock <= 1'b0;
         timer_one_clock_source <= T1_PROCESSOR;
         comp0_channel_out <= 1'b0;
         comp1_channel_out <= 1'b0;
      end else begin
         case (cnt_ctrl[CTRL_OUTSEL_LSB +: 2])
            OUT_INPUT: sense_pin_out <= chan0_data;
            OUT_INTERRUPT: sense_pin_out <= counter_interrupt;
            OUT_LOW: sense_pin_out <= low_count[COUNT_WIDTH-1];
            default: sense_pin_out <= high_count[COUNT_WIDTH-1];
         endcase
         switch_clock <= cnt_ctrl[CTRL_SWCLK] ? pseudo_random_seq : presc_level;
         if (sigma_mode) timer_one_clock_source <= T1_PRESCALED;
         else timer_one_clock_source <= timer_one_config ? T1_SLOW_32K : T1_PROCESSOR;
         comp0_channel_out <= chan0_data;
         comp1_channel_out <= lut_out[1];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_enabled_count;
      enable && sigma_mode && state == ST_COUNT;
   endsequence
   // One counter tick moves the low count by exactly one on the following edge
   sequence s_tick_step;
      ##1 low_count == $past(low_count) + 1'b1;
   endsequence

   property p_chan_select;
      ##1 comp0_channel_out == $past(chan_cfg[CFG_DATA_SEL] ? cmp_sync[2] : lut_out[0]);
   endproperty
   a_chan_select: assert property (p_chan_select) else $error("channel data select");

   property p_fn_xor;
      func_sel[FN0_LSB +: 4] == FN_XOR |-> lut_out[0] == (cmp_sync[0] ^ cmp_sync[1]);
   endproperty
   a_fn_xor: assert property (p_fn_xor) else $error("code 6h not xor");

   property p_fn_fixed;
      (func_sel[FN1_LSB +: 4] == FN_TRUE |-> lut_out[1]) and
      (func_sel[FN1_LSB +: 4] == FN_FALSE |-> !lut_out[1]) and
      (func_sel[FN1_LSB +: 4] == FN_A |-> lut_out[1] == cmp_sync[1]) and
      (func_sel[FN1_LSB +: 4] == FN_AND |-> lut_out[1] == (cmp_sync[1] & cmp_sync[0]));
   endproperty
   a_fn_fixed: assert property (p_fn_fixed) else $error("fixed function codes");

   property p_fn_complement;
      (func_sel[FN0_LSB +: 4] == FN_A_NOT_B |-> lut_out[0] == (cmp_sync[0] & ~cmp_sync[1])) and
      (func_sel[FN0_LSB +: 4] == FN_NOT_A |-> lut_out[0] == ~cmp_sync[0]) and
      (func_sel[FN0_LSB +: 4] == FN_NOR |-> lut_out[0] == ~(cmp_sync[0] | cmp_sync[1]));
   endproperty
   a_fn_complement: assert property (p_fn_complement) else $error("complement codes");

   property p_disable_clears;
      !enable |=> low_count == '0 && high_count == '0 && state == ST_IDLE;
   endproperty
   a_disable_clears: assert property (p_disable_clears) else $error("disable keeps count");

   property p_no_sigma_hold;
      !sigma_mode && enable && $past(enable) |=> $stable(low_count) && $stable(high_count);
   endproperty
   a_no_sigma_hold: assert property (p_no_sigma_hold) else $error("count without mode");

   property p_count_step;
      s_enabled_count ##0 count_tick |-> s_tick_step;
   endproperty
   a_count_step: assert property (p_count_step) else $error("low count missed tick");

   property p_event_stop;
      mode == MODE_EVENT && state == ST_COUNT && counter_interrupt && enable |=> state == ST_DONE;
   endproperty
   a_event_stop: assert property (p_event_stop) else $error("event mode did not stop");

   property p_period_start;
      mode == MODE_PERIOD && state == ST_ARMED && in_rise && enable |=> state == ST_COUNT;
   endproperty
   a_period_start: assert property (p_period_start) else $error("period start");

   property p_timer_source;
      sigma_mode |=> timer_one_clock_source == T1_PRESCALED;
   endproperty
   a_timer_source: assert property (p_timer_source) else $error("timer clock source");

   property p_ratio_eight;
      // A ratio rewrite inside the window legally restarts the spacing
      chan_cfg[CFG_RATIO_LSB +: 2] == 2'h3 && count_tick |=>
         (!count_tick || chan_cfg[CFG_RATIO_LSB +: 2] != 2'h3) [*7];
   endproperty
   a_ratio_eight: assert property (p_ratio_eight) else $error("divide by 8 wrong");
endmodule : sense_counter_comp_logic
`default_nettype wire

// ==== design/sense_pkg.sv ====
// Functional notes
// - Channel 0 data select: 0 routes function output, 1 routes comparator 0 latch.
// - Bits 7:4 pick channel 1 function; A is comparator 1, B comparator 0.
// - Bits 3:0 pick channel 0 function; A is comparator 0, B comparator 1.
// - Codes 6h XOR, 7h OR, 8h NOR, 9h XNOR.
// - Codes 0h false, Fh true, 3h A, 5h B, 1h A AND B.
// - Bits 7:6 pick pin output: input, counter interrupt, low out, high out.
// - Bit 5 picks switch clock: prescaled oscillator or pseudo-random sequence.
// - Bit 4 picks divider source: main oscillator or prescaled oscillator.
// - Bit 3 enables sigma-delta mode: timer one on prescaled clock, counters may count.
// - Sigma-delta off: timer one uses processor or 32 kHz clock per its config.
// - Prescaled divider runs freely, never stopped or restarted.
// - Mode 00b: start on enable, stop on counter interrupt event.
// - Mode 01b: start on next input rising edge, stop on falling edge.
// - Mode 10b: start on input rising edge, stop on next rising edge.
// - Mode 11b: start on enable, count until disabled.
// - Enable bit 0 clear halts counting and zeroes all counters.
// - Counter clock is source divided by 1, 2, 4 or 8 for codes 00b..11b.
// - 8-bit high and low counters, independent or chained as 16 bits.
`default_nettype none
package sense_pkg;
   localparam logic [7:0] ADDR_FUNC_SEL = 8'h7c;
   localparam logic [7:0] ADDR_CHAN_CFG = 8'h80;
   localparam logic [7:0] ADDR_CNT_CTRL = 8'ha0;
   localparam logic [7:0] ADDR_STATUS = 8'ha4;
   localparam logic [7:0] RESET_FUNC_SEL = 8'h00;
   localparam logic [7:0] RESET_CNT_CTRL = 8'h00;
   localparam logic [3:0] RESET_CHAN_CFG = 4'h0;
   localparam int FN1_LSB = 4;
   localparam int FN0_LSB = 0;
   localparam int CTRL_OUTSEL_LSB = 6;
   localparam int CTRL_SWCLK = 5;
   localparam int CTRL_SRCSEL = 4;
   localparam int CTRL_SIGMA = 3;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_EN = 0;
   localparam int CFG_DATA_SEL = 0;
   localparam int CFG_RATIO_LSB = 1;
   localparam int CFG_CHAIN = 3;
   localparam int STAT_LOW_LSB = 0;
   localparam int STAT_HIGH_LSB = 8;
   localparam int STAT_ACTIVE = 16;
   localparam int STAT_CH0 = 17;
   localparam int STAT_CH1 = 18;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] OUT_INPUT = 2'h0;
   localparam logic [1:0] OUT_INTERRUPT = 2'h1;
   localparam logic [1:0] OUT_LOW = 2'h2;
   localparam logic [1:0] OUT_HIGH = 2'h3;
   localparam logic [1:0] T1_PROCESSOR = 2'h0;
   localparam logic [1:0] T1_SLOW_32K = 2'h1;
   localparam logic [1:0] T1_PRESCALED = 2'h2;
   localparam logic [3:0] FN_FALSE = 4'h0;
   localparam logic [3:0] FN_AND = 4'h1;
   localparam logic [3:0] FN_A_NOT_B = 4'h2;
   localparam logic [3:0] FN_A = 4'h3;
   localparam logic [3:0] FN_XOR = 4'h6;
   localparam logic [3:0] FN_NOR = 4'h8;
   localparam logic [3:0] FN_NOT_A = 4'hc;
   localparam logic [3:0] FN_TRUE = 4'hf;
   localparam int PRESCALE_DIV = 2;
   typedef enum logic [1:0] {
      MODE_EVENT = 2'h0,
      MODE_PULSE = 2'h1,
      MODE_PERIOD = 2'h2,
      MODE_CONTINUOUS = 2'h3
   } count_mode_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ARMED = 2'h1,
      ST_COUNT = 2'h3,
      ST_DONE = 2'h2
   } count_state_type;
endpackage : sense_pkg
`default_nettype wire

// ==== design/sync_two_ff.sv ====
`default_nettype none
module sync_two_ff #(
   parameter int WIDTH = 3
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_one;

   always_ff @(posedge clk) begin
      if (reset) begin
         stage_one <= '0;
         sync_out <= '0;
      end else begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end
endmodule : sync_two_ff
`default_nettype wire

// ==== design/comp_function_unit.sv ====
`default_nettype none
module comp_function_unit (
   input wire logic [3:0] function_code,
   input wire logic operand_a,
   input wire logic operand_b,
   output logic result
);
   // Code bit {~A,~B} is the truth table entry, so every code maps directly
   always_comb begin
      result = function_code[{~operand_a, ~operand_b}];
   end
endmodule : comp_function_unit
`default_nettype wire

// ==== test/sense_counter_comp_logic_test.sv ====
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module sense_counter_comp_logic_test
   import sense_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 12000;
   logic clk, reset, awvalid, wvalid, bready, arvalid, rready;
   logic comp0_raw, comp1_raw, comp0_latch, pseudo_random_seq, timer_one_config;
   logic awready, wready, bvalid, arready, rvalid, sense_pin_out, switch_clock;
   logic comp0_channel_out, comp1_channel_out;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, timer_one_clock_source, rr;
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;

   sense_counter_comp_logic #(.COUNT_WIDTH(8), .PRESCALE(2)) sense_counter_comp_logic_inst (
      .clk(clk), .reset(reset), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .comp0_raw(comp0_raw), .comp1_raw(comp1_raw), .comp0_latch(comp0_latch),
      .pseudo_random_seq(pseudo_random_seq), .timer_one_config(timer_one_config),
      .sense_pin_out(sense_pin_out), .switch_clock(switch_clock),
      .timer_one_clock_source(timer_one_clock_source),
      .comp0_channel_out(comp0_channel_out), .comp1_channel_out(comp1_channel_out));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Expected function outputs written out per code, independent of any bit indexing
   function automatic logic fexp(input logic [3:0] c, input logic a, input logic b);
      case (c)
         4'h0: return 1'b0;
         4'h1: return a & b;
         4'h2: return a & ~b;
         4'h3: return a;
         4'h4: return ~a & b;
         4'h5: return b;
         4'h6: return a ^ b;
         4'h7: return a | b;
         4'h8: return ~(a | b);
         4'h9: return ~(a ^ b);
         4'ha: return ~b;
         4'hb: return a | ~b;
         4'hc: return ~a;
         4'hd: return ~a | b;
         4'he: return ~(a & b);
         default: return 1'b1;
      endcase
   endfunction : fexp

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rr = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rv = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask : rd

   // Mode bits go in while disabled, then the same value with enable
   task automatic ctl(input logic [7:0] v);
      wr(ADDR_CNT_CTRL, {24'h00_0000, v & 8'hfe});
      wr(ADDR_CNT_CTRL, {24'h00_0000, v});
   endtask : ctl

   task automatic t_regs;
      rd(ADDR_FUNC_SEL);
      `CHK(rv, 32'h0000_0000)
      rd(ADDR_CNT_CTRL);
      `CHK(rv, 32'h0000_0000)
      wr(ADDR_FUNC_SEL, 32'h0000_00a5);
      rd(ADDR_FUNC_SEL);
      `CHK(rv, 32'h0000_00a5)
      rd(8'h90);
      `CHK(rr, RESP_SLVERR)
      wr(8'h90, 32'h0000_0001);
      `CHK(rr, RESP_SLVERR)
      $display("test regs done");
   endtask : t_regs

   task automatic t_func;
      logic [3:0] c;
      logic [1:0] ab;
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         wr(ADDR_FUNC_SEL, {24'h00_0000, ~c, c});
         for (int j = 0; j < 4; j++) begin
            ab = 2'(j);
            comp0_raw <= ab[1];
            comp1_raw <= ab[0];
            cyc(5);
            `CHK(comp0_channel_out, fexp(c, ab[1], ab[0]))
            `CHK(comp1_channel_out, fexp(~c, ab[0], ab[1]))
         end
      end
      $display("test func done");
   endtask : t_func

   task automatic t_select;
      wr(ADDR_FUNC_SEL, 32'h0000_0000);
      wr(ADDR_CHAN_CFG, 32'h0000_0001);
      comp0_latch <= 1'b1;
      cyc(5);
      `CHK(comp0_channel_out, 1'b1)
      `CHK(comp1_channel_out, 1'b0)
      comp0_latch <= 1'b0;
      cyc(5);
      `CHK(comp0_channel_out, 1'b0)
      comp0_latch <= 1'b1;
      wr(ADDR_CHAN_CFG, 32'h0000_0000);
      cyc(5);
      `CHK(comp0_channel_out, 1'b0)
      comp0_latch <= 1'b0;
      $display("test select done");
   endtask : t_select

   task automatic t_clocks;
      int n;
      logic prev;
      wr(ADDR_CNT_CTRL, 32'h0000_0020);
      pseudo_random_seq <= 1'b1;
      cyc(3);
      `CHK(switch_clock, 1'b1)
      pseudo_random_seq <= 1'b0;
      cyc(3);
      `CHK(switch_clock, 1'b0)
      wr(ADDR_CNT_CTRL, 32'h0000_0000);
      n = 0;
      prev = switch_clock;
      repeat (20) begin
         @(posedge clk);
         if (switch_clock !== prev) n++;
         prev = switch_clock;
      end
      `CHK((n >= 9) && (n <= 11), 1'b1)
      timer_one_config <= 1'b0;
      cyc(3);
      `CHK(timer_one_clock_source, T1_PROCESSOR)
      timer_one_config <= 1'b1;
      cyc(3);
      `CHK(timer_one_clock_source, T1_SLOW_32K)
      wr(ADDR_CNT_CTRL, 32'h0000_0008);
      cyc(2);
      `CHK(timer_one_clock_source, T1_PRESCALED)
      wr(ADDR_CNT_CTRL, 32'h0000_0000);
      $display("test clocks done");
   endtask : t_clocks

   // Both counters tick together when not chained, so both land in one window
   task automatic run_cont(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi,
                           input logic pin);
      ctl(v);
      cyc(150);
      rd(ADDR_STATUS);
      `CHK(rv[16], 1'b1)
      `CHK((rv[7:0] >= lo) && (rv[7:0] <= hi), 1'b1)
      `CHK((rv[15:8] >= lo) && (rv[15:8] <= hi), 1'b1)
      `CHK(sense_pin_out, pin)
      wr(ADDR_CNT_CTRL, 32'h0000_0000);
      rd(ADDR_STATUS);
      `CHK(rv[16:0], 17'h0_0000)
   endtask : run_cont

   task automatic t_cont;
      run_cont(8'h8f, 8'h8c, 8'ha5, 1'b1);
      wr(ADDR_CHAN_CFG, 32'h0000_0006);
      run_cont(8'hcf, 8'h10, 8'h16, 1'b0);
      wr(ADDR_CHAN_CFG, 32'h0000_0000);
      run_cont(8'hdf, 8'h43, 8'h55, 1'b0);
      ctl(8'h07);
      cyc(20);
      rd(ADDR_STATUS);
      `CHK(rv[15:0], 16'h0000)
      wr(ADDR_CNT_CTRL, 32'h0000_0000);
      // Chained: about 302 ticks, so the high half has taken exactly one carry
      wr(ADDR_CHAN_CFG, 32'h0000_0008);
      ctl(8'h0f);
      cyc(300);
      rd(ADDR_STATUS);
      `CHK(rv[15:8], 8'h01)
      `CHK((rv[7:0] >= 8'h28) && (rv[7:0] <= 8'h34), 1'b1)
      wr(ADDR_CNT_CTRL, 32'h0000_0000);
      wr(ADDR_CHAN_CFG, 32'h0000_0000);
      $display("test cont done");
   endtask : t_cont

   task automatic t_event;
      int n;
      ctl(8'h49);
      n = 0;
      repeat (300) begin
         @(posedge clk);
         if (sense_pin_out === 1'b1) n++;
      end
      `CHK(n == 1, 1'b1)
      rd(ADDR_STATUS);
      `CHK(rv[16], 1'b0)
      `CHK(rv[7:0] <= 8'h03, 1'b1)
      wr(ADDR_CNT_CTRL, 32'h0000_0000);
      $display("test event done");
   endtask : t_event

   task automatic t_pulse;
      wr(ADDR_FUNC_SEL, 32'h0000_0033);
      comp0_raw <= 1'b0;
      ctl(8'h0b);
      cyc(20);
      rd(ADDR_STATUS);
      `CHK(rv[16:0], 17'h0_0000)
      `CHK(sense_pin_out, 1'b0)
      comp0_raw <= 1'b1;
      cyc(6);
      `CHK(sense_pin_out, 1'b1)
      cyc(24);
      comp0_raw <= 1'b0;
      cyc(10);
      rd(ADDR_STATUS);
      `CHK(rv[16], 1'b0)
      `CHK((rv[7:0] >= 8'h1a) && (rv[7:0] <= 8'h22), 1'b1)
      wr(ADDR_CNT_CTRL, 32'h0000_0000);
      $display("test pulse done");
   endtask : t_pulse

   task automatic t_period;
      ctl(8'h0d);
      cyc(10);
      comp0_raw <= 1'b1;
      cyc(10);
      comp0_raw <= 1'b0;
      cyc(10);
      rd(ADDR_STATUS);
      `CHK(rv[16], 1'b1)
      comp0_raw <= 1'b1;
      cyc(10);
      rd(ADDR_STATUS);
      `CHK(rv[16], 1'b0)
      `CHK((rv[7:0] >= 8'h12) && (rv[7:0] <= 8'h1c), 1'b1)
      comp0_raw <= 1'b0;
      wr(ADDR_CNT_CTRL, 32'h0000_0000);
      $display("test period done");
   endtask : t_period

   task automatic tally_and_finish;
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         error_cnt++;
         $display("BAD %0t timeout", $time);
         tally_and_finish;
      end
   end

   initial begin
      reset = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {comp0_raw, comp1_raw, comp0_latch, pseudo_random_seq, timer_one_config} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_regs;
      t_func;
      t_select;
      t_clocks;
      t_cont;
      t_event;
      t_pulse;
      t_period;
      tally_and_finish;
   end
endmodule : sense_counter_comp_logic_test
`undef CHK
`default_nettype wire
